// *** logic/wot_cfg.svh ***
// Register indices, field positions and encodings of the wait one-shot timer
`ifndef WOT_CFG_SVH
`define WOT_CFG_SVH
`define WOT_IDX_CTRL 10'h108
`define WOT_IDX_OSC 10'h109
`define WOT_IDX_IOC 10'h10a
`define WOT_IDX_MODE 10'h10b
`define WOT_IDX_PRE 10'h10c
`define WOT_IDX_SEC 10'h10d
`define WOT_IDX_PRI 10'h10e
`define WOT_IOC_LVL 0
`define WOT_IOC_OSW 1
`define WOT_IOC_TEN 2
`define WOT_IOC_TPOL 3
`define WOT_CTRL_START 0
`define WOT_CTRL_STATUS 1
`define WOT_CTRL_FSTOP 2
`define WOT_OSC_GO 0
`define WOT_OSC_STOP 1
`define WOT_OSC_ACT 2
`define WOT_SRC_F1 2'h0
`define WOT_SRC_F2 2'h1
`define WOT_SRC_F8 2'h2
`define WOT_SRC_EXT 2'h3
`define WOT_DIV8_LAST 3'h7
`define WOT_CNT_ONE 8'h01
`define WOT_CNT_ZERO 8'h00
`endif

// *** logic/wot_pkg.sv ***
// Types shared by the wait one-shot timer files
package wot_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_PULSE} phase_type;
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [11:0] adr;
    logic [31:0] dat;
    logic [3:0] sel;
  } wb_req_type;
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } wb_rsp_type;
  typedef struct packed {
    logic lvl;
    logic osw;
    logic ten;
    logic tpol;
    logic start_bit;
    logic stage;
    logic status;
    logic go_pend;
    logic stop_pend;
    logic arm;
    logic active;
    phase_type phase;
    logic [1:0] src;
    logic [7:0] pre_rld;
    logic [7:0] pri_rld;
    logic [7:0] sec_rld;
    logic [7:0] pre_cnt;
    logic [7:0] cnt;
    logic ack;
    logic [7:0] rdat;
    logic irq;
    logic pin;
  } ctl_state_type;
endpackage

// *** logic/tick_source.sv ***
// Count source strobe: clock, half, eighth, or the other timer's underflow
`timescale 1ns/10ps
`include "wot_cfg.svh"
module tick_source (
  input wire logic clk_i, // 40 MHz clock
  input wire logic rst_i, // Synchronous reset
  input wire logic [1:0] sel_i, // Source select
  input wire logic ext_uf_i, // Other timer underflow, same clock
  output logic tick_o // One-cycle count source strobe
);
  logic [2:0] div_reg;
  logic [2:0] div_next;
  logic tick_reg;
  logic tick_next;

  always_comb begin
    div_next = div_reg + 3'h1;
    case (sel_i)
      `WOT_SRC_F1: tick_next = 1'b1;
      `WOT_SRC_F2: tick_next = div_reg[0];
      `WOT_SRC_F8: tick_next = (div_reg == `WOT_DIV8_LAST);
      default: tick_next = ext_uf_i;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_reg <= 3'h0;
      tick_reg <= 1'b0;
    end else begin
      div_reg <= div_next;
      tick_reg <= tick_next;
    end
  end

  assign tick_o = tick_reg;
endmodule

// *** logic/trig_detect.sv ***
// Pin synchroniser and selectable edge detector for the external trigger
`timescale 1ns/10ps
module trig_detect (
  input wire logic clk_i, // 40 MHz clock
  input wire logic rst_i, // Synchronous reset
  input wire logic pin_i, // Asynchronous trigger pin
  input wire logic rise_i, // 1 rising edge, 0 falling edge
  output logic edge_o // One-cycle edge pulse
);
  logic [2:0] sh_reg;
  logic [2:0] sh_next;
  logic edge_reg;
  logic edge_next;

  always_comb begin
    sh_next = {sh_reg[1:0], pin_i};
    // Only the second and third stages feed the edge logic
    edge_next = rise_i ? (sh_reg[1] && !sh_reg[2]) : (!sh_reg[1] && sh_reg[2]); // R4
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sh_reg <= 3'h0;
      edge_reg <= 1'b0;
    end else begin
      sh_reg <= sh_next;
      edge_reg <= edge_next;
    end
  end

  assign edge_o = edge_reg;
endmodule

// *** logic/wait_one_shot_timer.sv ***
// Wait one-shot timer with prescaler, Wishbone registers and trigger pin
//
// Contract
// R1: Level select 0 gives high pulse, low otherwise; 1 inverts both.
// R2: Software keeps the output switch bit at zero in this mode.
// R3: Trigger enable 0 ignores the pin; 1 lets a pin edge start a shot.
// R4: Trigger polarity 0 means falling edge, 1 means rising edge.
// R5: Bits four to seven of output control read zero.
// R6: After reset the timer is idle until software starts it.
// R7: Prescaler and counter are read as separate bytes and may shift between.
// R8: Clearing start or one-shot stop reloads the counters, then halts.
// R9: Status rises one to two source cycles after start; counting follows it.
// R10: Status falls one to two source cycles after start cleared; then halts.
// R11: Software touches only the status flag while status lags its request.
// R12: Forced stop halts counting at once.
// R13: Active flag follows one-shot start or stop after one to two source cycles.
// R14: Start and stop racing each other may leave either active value.
// R15: Other timer feeding the source runs in timer, pulse or event mode.
// R16: Prescaler rewrites while counting are three source cycles apart.
// R17: Primary rewrites while counting are three prescaler underflows apart.
// R18: Wait (n+1)(m+1) cycles, then pulse (n+1)(p+1) cycles.
// R19: Primary underflow loads secondary; secondary underflow ends the shot.
// R20: A trigger while active is ignored.
// R21: Interrupt request coincides with the end of the output pulse.
`timescale 1ns/10ps
`include "wot_cfg.svh"
module wait_one_shot_timer (
  input wire logic clk_i, // 40 MHz clock
  input wire logic rst_i, // Synchronous reset, active high
  input wire wot_pkg::wb_req_type wb_i, // Wishbone request
  output wot_pkg::wb_rsp_type wb_o, // Wishbone answer
  input wire logic ext_trigger_pin_i, // External trigger pin, asynchronous
  input wire logic timer_a_underflow_i, // Other timer underflow strobe
  output logic pulse_output_pin_o, // Pulse output pin
  output logic timer_irq_o // One-cycle request at pulse end
);
  wot_pkg::ctl_state_type st_reg;
  wot_pkg::ctl_state_type st_next;
  logic tick;
  logic pin_edge;
  logic access;
  logic wr;
  logic [7:0] wd;
  logic fstop_wr;
  logic go_wr;
  logic stop_wr;
  logic trig;
  logic stop_os;
  logic halt;

  function automatic logic is_reg(input logic [11:0] adr, input logic [9:0] idx);
    is_reg = (adr[11:2] == idx);
  endfunction

  tick_source u_tick (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sel_i(st_reg.src),
    .ext_uf_i(timer_a_underflow_i),
    .tick_o(tick)
  );

  trig_detect u_trig (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(ext_trigger_pin_i),
    .rise_i(st_reg.tpol),
    .edge_o(pin_edge)
  );

  always_comb begin
    st_next = st_reg;
    st_next.irq = 1'b0;
    stop_os = 1'b0;
    access = wb_i.cyc && wb_i.stb && !st_reg.ack;
    // Writes commit on the edge where the master sees ack
    wr = st_reg.ack && wb_i.cyc && wb_i.stb && wb_i.we && wb_i.sel[0];
    wd = wb_i.dat[7:0];
    fstop_wr = wr && is_reg(wb_i.adr, `WOT_IDX_CTRL) && wd[`WOT_CTRL_FSTOP];
    go_wr = wr && is_reg(wb_i.adr, `WOT_IDX_OSC) && wd[`WOT_OSC_GO];
    stop_wr = wr && is_reg(wb_i.adr, `WOT_IDX_OSC) && wd[`WOT_OSC_STOP];
    // A second trigger while one is pending is ignored
    trig = (go_wr || (pin_edge && st_reg.ten)) && st_reg.status
      && !st_reg.active && !st_reg.go_pend; // R3 R20

    st_next.ack = access;
    if (access) begin
      st_next.rdat = `WOT_CNT_ZERO;
      if (is_reg(wb_i.adr, `WOT_IDX_CTRL)) begin
        st_next.rdat[`WOT_CTRL_START] = st_reg.start_bit;
        st_next.rdat[`WOT_CTRL_STATUS] = st_reg.status;
      end else if (is_reg(wb_i.adr, `WOT_IDX_OSC)) begin
        st_next.rdat[`WOT_OSC_ACT] = st_reg.active;
      end else if (is_reg(wb_i.adr, `WOT_IDX_IOC)) begin
        // Upper nibble stays zero
        st_next.rdat[`WOT_IOC_LVL] = st_reg.lvl; // R5
        st_next.rdat[`WOT_IOC_OSW] = st_reg.osw;
        st_next.rdat[`WOT_IOC_TEN] = st_reg.ten;
        st_next.rdat[`WOT_IOC_TPOL] = st_reg.tpol;
      end else if (is_reg(wb_i.adr, `WOT_IDX_MODE)) begin
        st_next.rdat[1:0] = st_reg.src;
      end else if (is_reg(wb_i.adr, `WOT_IDX_PRE)) begin
        st_next.rdat = st_reg.pre_cnt; // R7
      end else if (is_reg(wb_i.adr, `WOT_IDX_PRI)) begin
        st_next.rdat = st_reg.cnt; // R7
      end else if (is_reg(wb_i.adr, `WOT_IDX_SEC)) begin
        st_next.rdat = st_reg.sec_rld;
      end
    end

    // Two source-cycle stages between request and status
    if (tick) begin
      st_next.stage = st_reg.start_bit; // R9 R10
      st_next.status = st_reg.stage; // R9 R10
    end

    if (tick && st_reg.active && st_reg.status && st_reg.phase != wot_pkg::ST_IDLE) begin
      if (st_reg.pre_cnt == `WOT_CNT_ZERO) begin
        st_next.pre_cnt = st_reg.pre_rld; // R18
        if (st_reg.cnt == `WOT_CNT_ZERO) begin
          if (st_reg.phase == wot_pkg::ST_WAIT) begin
            st_next.cnt = st_reg.sec_rld; // R19
            st_next.phase = wot_pkg::ST_PULSE;
          end else begin
            st_next.cnt = st_reg.pri_rld; // R19
            st_next.phase = wot_pkg::ST_IDLE;
            st_next.active = 1'b0;
            st_next.irq = 1'b1; // R21
          end
        end else begin
          st_next.cnt = st_reg.cnt - `WOT_CNT_ONE; // R18
        end
      end else begin
        st_next.pre_cnt = st_reg.pre_cnt - `WOT_CNT_ONE; // R18
      end
    end

    // A pending request is armed at one tick and applied at the next
    if (tick && (st_reg.go_pend || st_reg.stop_pend)) begin
      st_next.arm = !st_reg.arm; // R13
      if (st_reg.arm) begin
        st_next.go_pend = 1'b0;
        st_next.stop_pend = 1'b0;
        if (st_reg.stop_pend) begin
          stop_os = 1'b1; // R13
        end else begin
          st_next.active = 1'b1; // R13
          st_next.phase = wot_pkg::ST_WAIT;
        end
      end
    end

    if (wr) begin
      if (is_reg(wb_i.adr, `WOT_IDX_IOC)) begin
        st_next.lvl = wd[`WOT_IOC_LVL];
        st_next.osw = wd[`WOT_IOC_OSW];
        st_next.ten = wd[`WOT_IOC_TEN];
        st_next.tpol = wd[`WOT_IOC_TPOL];
      end
      if (is_reg(wb_i.adr, `WOT_IDX_CTRL)) begin
        st_next.start_bit = wd[`WOT_CTRL_START] && !wd[`WOT_CTRL_FSTOP];
      end
      if (is_reg(wb_i.adr, `WOT_IDX_MODE)) begin
        st_next.src = wd[1:0];
      end
      // While counting only the reload value takes the write
      if (is_reg(wb_i.adr, `WOT_IDX_PRE)) begin
        st_next.pre_rld = wd;
        if (!st_reg.status) begin
          st_next.pre_cnt = wd;
        end
      end
      if (is_reg(wb_i.adr, `WOT_IDX_PRI)) begin
        st_next.pri_rld = wd;
        if (!st_reg.status) begin
          st_next.cnt = wd;
        end
      end
      if (is_reg(wb_i.adr, `WOT_IDX_SEC)) begin
        st_next.sec_rld = wd;
      end
    end

    // A stop overrides a pending or same-cycle start
    if (trig) begin
      st_next.go_pend = 1'b1; // R14
      st_next.stop_pend = 1'b0;
    end
    if (stop_wr) begin
      st_next.stop_pend = 1'b1; // R14
      st_next.go_pend = 1'b0;
    end
    if (fstop_wr) begin
      st_next.stage = 1'b0; // R12
      st_next.status = 1'b0; // R12
    end

    halt = stop_os || (st_reg.status && !st_next.status);
    if (halt) begin
      st_next.active = 1'b0; // R8
      st_next.phase = wot_pkg::ST_IDLE;
      st_next.cnt = st_reg.pri_rld; // R8
      st_next.pre_cnt = st_reg.pre_rld; // R8
      st_next.go_pend = 1'b0;
      st_next.stop_pend = 1'b0;
      st_next.arm = 1'b0;
    end
    st_next.pin = (st_next.phase == wot_pkg::ST_PULSE) ^ st_next.lvl; // R1
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= '0; // R6
    end else begin
      st_reg <= st_next;
    end
  end

  assign wb_o = '{ack: st_reg.ack, dat: {24'h000000, st_reg.rdat}};
  assign pulse_output_pin_o = st_reg.pin;
  assign timer_irq_o = st_reg.irq;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_go_armed;
    tick && st_reg.arm && st_reg.go_pend && !stop_wr && !fstop_wr;
  endsequence

  sequence s_status_lag;
    st_reg.status && !tick && !fstop_wr;
  endsequence

  sequence s_pin_ready;
    pin_edge && st_reg.ten && st_reg.status && !st_reg.active && !st_reg.go_pend
      && !stop_wr && !halt;
  endsequence

  sequence s_prescale_step;
    tick && st_reg.active && st_reg.status && st_reg.pre_cnt != `WOT_CNT_ZERO && !halt;
  endsequence

  property p_level;
    (st_reg.phase == wot_pkg::ST_PULSE) |-> pulse_output_pin_o != st_reg.lvl;
  endproperty
  a_level: assert property (p_level) else $error("pulse level wrong"); // R1

  property p_idle_level;
    (st_reg.phase == wot_pkg::ST_IDLE) |-> pulse_output_pin_o == st_reg.lvl;
  endproperty
  a_idle_level: assert property (p_idle_level) else $error("idle level wrong"); // R1

  property p_ioc_high_zero;
    access && !wb_i.we && is_reg(wb_i.adr, `WOT_IDX_IOC) |=> wb_o.dat[7:4] == 4'h0;
  endproperty
  a_ioc_high_zero: assert property (p_ioc_high_zero) else $error("ioc high bits"); // R5

  property p_reset_idle;
    $fell(rst_i) |-> !st_reg.status && !st_reg.active && !st_reg.start_bit;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("not idle after reset"); // R6

  property p_status_rise;
    $rose(st_reg.status) |-> $past(tick) && $past(st_reg.stage) && st_reg.start_bit;
  endproperty
  a_status_rise: assert property (p_status_rise) else $error("status rose early"); // R9

  property p_status_hold;
    s_status_lag |=> st_reg.status;
  endproperty
  a_status_hold: assert property (p_status_hold) else $error("status fell early"); // R10

  property p_forced_stop;
    fstop_wr |=> !st_reg.status && !st_reg.active && !st_reg.start_bit;
  endproperty
  a_forced_stop: assert property (p_forced_stop) else $error("forced stop late"); // R12

  property p_stop_reload;
    $fell(st_reg.status) |-> st_reg.cnt == $past(st_reg.pri_rld) && !st_reg.active;
  endproperty
  a_stop_reload: assert property (p_stop_reload) else $error("no reload at stop"); // R8

  property p_go_delay;
    s_go_armed |=> st_reg.active && st_reg.phase == wot_pkg::ST_WAIT;
  endproperty
  a_go_delay: assert property (p_go_delay) else $error("active flag late"); // R13

  property p_active_rise;
    $rose(st_reg.active) |-> $past(tick) && $past(st_reg.arm);
  endproperty
  a_active_rise: assert property (p_active_rise) else $error("active rose off tick"); // R13

  property p_no_retrigger;
    st_reg.active && !st_reg.go_pend |=> !st_reg.go_pend;
  endproperty
  a_no_retrigger: assert property (p_no_retrigger) else $error("retrigger taken"); // R20

  property p_pulse_load;
    $rose(st_reg.phase == wot_pkg::ST_PULSE) |-> st_reg.cnt == $past(st_reg.sec_rld);
  endproperty
  a_pulse_load: assert property (p_pulse_load) else $error("secondary not loaded"); // R19

  property p_irq_end;
    timer_irq_o |-> !st_reg.active && pulse_output_pin_o == st_reg.lvl
      && st_reg.cnt == $past(st_reg.pri_rld);
  endproperty
  a_irq_end: assert property (p_irq_end) else $error("irq not at pulse end"); // R21

  property p_pin_gate;
    pin_edge && !st_reg.ten && !go_wr && !st_reg.go_pend |=> !st_reg.go_pend;
  endproperty
  a_pin_gate: assert property (p_pin_gate) else $error("disabled pin triggered"); // R3

  property p_pin_take;
    s_pin_ready |=> st_reg.go_pend;
  endproperty
  a_pin_take: assert property (p_pin_take) else $error("pin trigger lost"); // R3

  property p_no_count_stopped;
    !st_reg.status |-> !st_reg.active;
  endproperty
  a_no_count_stopped: assert property (p_no_count_stopped) else $error("active while stopped"); // R9

  property p_prescale_step;
    s_prescale_step |=> st_reg.pre_cnt == $past(st_reg.pre_cnt) - `WOT_CNT_ONE;
  endproperty
  a_prescale_step: assert property (p_prescale_step) else $error("prescaler step wrong"); // R18

  property p_irq_cause;
    timer_irq_o |-> $past(st_reg.phase) == wot_pkg::ST_PULSE
      && st_reg.phase == wot_pkg::ST_IDLE;
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq outside pulse end"); // R21

  property p_stop_wins;
    stop_wr && st_reg.go_pend && !halt |=> st_reg.stop_pend && !st_reg.go_pend;
  endproperty
  a_stop_wins: assert property (p_stop_wins) else $error("later stop lost"); // R14

  property p_stop_apply;
    tick && st_reg.arm && st_reg.stop_pend
      |=> !st_reg.active && st_reg.cnt == $past(st_reg.pri_rld);
  endproperty
  a_stop_apply: assert property (p_stop_apply) else $error("one-shot stop no reload"); // R8

  property p_status_fall;
    $fell(st_reg.status) |-> $past(fstop_wr) || ($past(tick) && !$past(st_reg.stage));
  endproperty
  a_status_fall: assert property (p_status_fall) else $error("status fell off tick"); // R10

  property p_count_read;
    access && !wb_i.we && is_reg(wb_i.adr, `WOT_IDX_PRI)
      |=> wb_o.dat[7:0] == $past(st_reg.cnt);
  endproperty
  a_count_read: assert property (p_count_read) else $error("count read wrong"); // R7
endmodule

// *** verif/trig_pin_model.sv ***
// Far side model: external trigger pin and the other timer's underflow
`timescale 1ns/10ps
module trig_pin_model (
  input wire logic clk_i, // 40 MHz clock
  input wire logic rst_i, // Synchronous reset
  input wire logic level_i, // Pin level wanted by the bench
  output logic pin_o, // Trigger pin
  output logic uf_o // Underflow strobe, one cycle in four
);
  logic [1:0] div_reg;
  // Pin is a plain driven level, so it never floats
  assign pin_o = level_i;
  // Other timer in plain timer mode: steady periodic underflow
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_reg <= 2'h0;
      uf_o <= 1'b0;
    end else begin
      div_reg <= div_reg + 2'h1;
      uf_o <= (div_reg == 2'h3);
    end
  end
endmodule

// *** verif/wait_one_shot_timer_tb.sv ***
// Register-level testbench of the wait one-shot timer
`timescale 1ns/10ps
`include "wot_cfg.svh"
module wait_one_shot_timer_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  wot_pkg::wb_req_type req = '0;
  wot_pkg::wb_rsp_type rsp;
  logic level = 1'b0;
  logic pin;
  logic uf;
  logic pulse;
  logic irq;
  logic [7:0] rd;
  int bad_count = 0;
  int check_count = 0;
  int len;
  int exp_len [4] = '{8, 16, 64, 32};
  logic [7:0] pio [4] = '{8'h0c, 8'h04, 8'h08, 8'h04};
  logic pfrom [4] = '{1'b0, 1'b1, 1'b0, 1'b0};
  int pexp [4] = '{32, 32, -1, -1};

  always #12.5 clk_i = ~clk_i;

  trig_pin_model trig_pin_model_inst (.clk_i(clk_i), .rst_i(rst_i), .level_i(level),
    .pin_o(pin), .uf_o(uf));
  wait_one_shot_timer wait_one_shot_timer_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_i(req),
    .wb_o(rsp), .ext_trigger_pin_i(pin), .timer_a_underflow_i(uf),
    .pulse_output_pin_o(pulse), .timer_irq_o(irq));

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  // Classic cycle; ack sampled at the edge, release right after it
  task automatic bus(input logic we, input logic [9:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge clk_i);
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: {idx, 2'h0}, dat: {24'h0, wd}, sel: 4'hf};
    do begin
      @(posedge clk_i);
      n++;
    end while (rsp.ack !== 1'b1 && n < 20);
    if (rsp.ack !== 1'b1) begin
      bad_count++;
      give_verdict();
    end
    rd = rsp.dat[7:0];
    req <= '0;
  endtask

  // Only the polled register is touched while a flag lags
  task automatic poll(input logic [9:0] idx, input int b, input logic v);
    int n;
    n = 0;
    do begin
      bus(1'b0, idx, 8'h00);
      n++;
    end while (rd[b] !== v && n < 40);
    check("polled flag", rd[b], v);
  endtask

  // Length of the next pulse in clocks, -1 if none starts within lim
  task automatic shot(input logic lvl, input int lim, output int n);
    int w;
    n = -1;
    w = 0;
    while (pulse === lvl && w < lim) begin
      @(negedge clk_i);
      w++;
    end
    if (pulse !== lvl) begin
      n = 0;
      while (pulse !== lvl && n < 600) begin
        @(negedge clk_i);
        n++;
      end
      check("irq at pulse end", irq, 1'b1);
    end
  endtask

  task automatic end_test(input string name);
    $display("test %s finished", name);
  endtask

  initial begin
    repeat (100000) @(posedge clk_i);
    bad_count++;
    give_verdict();
  end

  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(1'b0, `WOT_IDX_IOC, 8'h00);
    check("control reset", rd, 8'h00);
    bus(1'b0, `WOT_IDX_CTRL, 8'h00);
    check("idle after reset", rd, 8'h00);
    check("pin after reset", pulse, 1'b0);
    // Output switch kept zero, upper bits set to probe the empty field
    bus(1'b1, `WOT_IDX_IOC, 8'hf5);
    bus(1'b0, `WOT_IDX_IOC, 8'h00);
    check("empty bits", rd, 8'h05);
    bus(1'b1, `WOT_IDX_IOC, 8'h00);
    end_test("reset");
    // Counts loaded once while stopped
    bus(1'b1, `WOT_IDX_PRE, 8'h01);
    bus(1'b1, `WOT_IDX_PRI, 8'h13);
    bus(1'b1, `WOT_IDX_SEC, 8'h03);
    bus(1'b1, `WOT_IDX_CTRL, 8'h01);
    poll(`WOT_IDX_CTRL, `WOT_CTRL_STATUS, 1'b1);
    end_test("start");
    for (int s = 0; s < 4; s++) begin
      bus(1'b1, `WOT_IDX_MODE, {6'h00, s[1:0]});
      bus(1'b1, `WOT_IDX_OSC, 8'h01);
      poll(`WOT_IDX_OSC, `WOT_OSC_ACT, 1'b1);
      bus(1'b1, `WOT_IDX_OSC, 8'h01);
      shot(1'b0, 3000, len);
      check("pulse length", len, exp_len[s]);
      shot(1'b0, 100, len);
      check("no retrigger", len, -1);
      poll(`WOT_IDX_OSC, `WOT_OSC_ACT, 1'b0);
    end
    end_test("sources");
    bus(1'b1, `WOT_IDX_IOC, 8'h01);
    repeat (2) @(negedge clk_i);
    check("inverted idle", pulse, 1'b1);
    bus(1'b1, `WOT_IDX_OSC, 8'h01);
    shot(1'b1, 3000, len);
    check("low pulse length", len, 32);
    end_test("level");
    for (int k = 0; k < 4; k++) begin
      @(posedge clk_i);
      level <= pfrom[k];
      repeat (4) @(posedge clk_i);
      bus(1'b1, `WOT_IDX_IOC, pio[k]);
      @(posedge clk_i);
      level <= ~pfrom[k];
      shot(1'b0, 400, len);
      check("pin trigger", len, pexp[k]);
    end
    end_test("pin");
    bus(1'b1, `WOT_IDX_PRI, 8'hc8);
    bus(1'b1, `WOT_IDX_OSC, 8'h01);
    poll(`WOT_IDX_OSC, `WOT_OSC_ACT, 1'b1);
    bus(1'b1, `WOT_IDX_OSC, 8'h02);
    poll(`WOT_IDX_OSC, `WOT_OSC_ACT, 1'b0);
    bus(1'b0, `WOT_IDX_PRI, 8'h00);
    check("reload on stop", rd, 8'hc8);
    check("no pulse after stop", pulse, 1'b0);
    end_test("stop");
    bus(1'b1, `WOT_IDX_CTRL, 8'h05);
    bus(1'b0, `WOT_IDX_CTRL, 8'h00);
    check("forced stop", rd[`WOT_CTRL_STATUS], 1'b0);
    bus(1'b1, `WOT_IDX_CTRL, 8'h00);
    bus(1'b1, `WOT_IDX_CTRL, 8'h01);
    poll(`WOT_IDX_CTRL, `WOT_CTRL_STATUS, 1'b1);
    bus(1'b1, `WOT_IDX_CTRL, 8'h00);
    poll(`WOT_IDX_CTRL, `WOT_CTRL_STATUS, 1'b0);
    end_test("halt");
    give_verdict();
  end
endmodule
